// >>> pic_pkg.sv
/*
 * package for the prioritized interrupt controller: source indices,
 * edge mode encodings, status word field, acceptance timing and carriers.
 * assumes a single 20 MHz system clock domain.
 */
package pic_pkg;
    // number of maskable sources, indexed in priority order
    localparam int NUM_SRC = 15;
    localparam int SRC_W = 4;
    // source index, lowest index wins (priority 2..16)
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_EXT3 = 4'h3;
    localparam logic [3:0] SRC_UART0 = 4'h4;
    localparam logic [3:0] SRC_UART1 = 4'h5;
    localparam logic [3:0] SRC_SIO = 4'h6;
    localparam logic [3:0] SRC_TMR0 = 4'h7;
    localparam logic [3:0] SRC_ADC = 4'hC;
    localparam logic [3:0] SRC_WDWT = 4'hD;
    localparam logic [3:0] SRC_BIT = 4'hE;
    // number of external pins
    localparam int NUM_EXT = 4;
    // master enable position in the status word
    localparam int STATUS_MASTER_BIT = 2;
    // edge mode per pin, two bits each
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // address of the edge select register, kept for software reference
    localparam logic [7:0] EDGE_SEL_ADDR = 8'hEE;
    // acceptance sequence length in main clock cycles
    localparam int ACCEPT_CYCLES = 8;
    localparam logic [3:0] ACCEPT_LAST = 4'(ACCEPT_CYCLES - 1);
    // shared source discrimination bits
    localparam int SHR_WDT = 0;
    localparam int SHR_WT = 1;
    localparam int SHR_U0RX = 2;
    localparam int SHR_U0TX = 3;
    localparam int SHR_W = 4;

    // request offered to the core
    typedef struct packed {
        logic valid;
        logic [3:0] src;
    } pic_req_type;

    // software write of the request flags
    typedef struct packed {
        logic we;
        logic [14:0] data;
    } pic_flag_wr_type;

    // acceptance sequencer states, gray from idle to done; the return to idle flips both bits
    typedef enum logic [1:0] {
        PIC_IDLE = 2'b00,
        PIC_ACCEPT = 2'b01,
        PIC_DONE = 2'b11
    } pic_state_type;
endpackage

// >>> pic_ctrl.sv
/*
 * prioritized interrupt controller: request flags, edge detection on four
 * external pins, per-source enables, master enable gating, fixed priority
 * and an eight cycle acceptance sequence toward the core.
 * assumes peripheral event inputs are one-cycle pulses on i_clk and the
 * external pins are asynchronous; the core owns the status word and
 * clears its master flag when o_clr_iflag pulses.
 */
`timescale 1ns/100ps
module pic_ctrl (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // external pins, asynchronous
    input wire logic [3:0] i_ext_pin,
    // edge mode, two bits per pin
    input wire logic [7:0] i_external_edge_select,
    // peripheral event pulses
    input wire logic [4:0] i_timer_match,
    input wire logic i_interval_overflow,
    input wire logic i_conversion_done,
    input wire logic i_watchdog_match,
    input wire logic i_watch_match,
    input wire logic i_uart0_rx_done,
    input wire logic i_uart0_tx_done,
    input wire logic i_uart1_done,
    input wire logic i_sync_serial_done,
    // enables and status word from the core
    input wire logic [14:0] i_enable_flags,
    input wire logic [7:0] i_processor_status_word,
    // software access to flags
    input wire pic_pkg::pic_flag_wr_type i_flag_wr,
    input wire logic [3:0] i_shared_clr,
    // core handshake: start acceptance at instruction end
    input wire logic i_accept_start,
    // outputs
    output logic [14:0] o_request_flags,
    output logic [3:0] o_shared_source_flags,
    output pic_pkg::pic_req_type o_req,
    output logic o_busy,
    output logic o_clr_iflag,
    output logic o_vector_valid,
    output logic [3:0] o_vector_src
);
    // pin synchroniser and last sampled level
    logic [3:0] sync1_ff, sync2_ff, last_ff;
    // warm-up marks: edge history is trusted only once the chain has filled
    logic [2:0] warm_ff;
    logic [14:0] flags_ff, nxt_flags;
    logic [3:0] shared_ff, nxt_shared;
    pic_pkg::pic_state_type state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [3:0] src_ff, nxt_src;
    logic vec_ff, nxt_vec;
    logic clr_ff, nxt_clr;
    logic [3:0] ext_edge;
    logic [14:0] events;
    logic [14:0] armed;
    logic iflag;

    // priority search: lowest index of a set bit
    function automatic pic_pkg::pic_req_type pick(input logic [14:0] v);
        pic_pkg::pic_req_type r;
        r = '0;
        for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r.valid = 1'b1;
                r.src = 4'(i);
            end
        end
        return r;
    endfunction

    // two-stage pin synchroniser, then a third stage for edge detect
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            last_ff <= 4'h0;
            warm_ff <= 3'h0;
        end else begin
            sync1_ff <= i_ext_pin;
            sync2_ff <= sync1_ff;
            last_ff <= sync2_ff;
            warm_ff <= {warm_ff[1:0], 1'b1};
        end
    end

    // edge detection per pin according to its mode
    generate
        for (genvar g = 0; g < pic_pkg::NUM_EXT; g++) begin : g_edge
            logic rise, fall;
            // pins idling high would look like a rise just after reset
            assign rise = sync2_ff[g] & ~last_ff[g] & warm_ff[2];
            assign fall = ~sync2_ff[g] & last_ff[g] & warm_ff[2];
            // mode none keeps the pin quiet
            assign ext_edge[g] =
                ((i_external_edge_select[2*g+:2] == pic_pkg::EDGE_RISE) & rise) |
                ((i_external_edge_select[2*g+:2] == pic_pkg::EDGE_FALL) & fall) |
                ((i_external_edge_select[2*g+:2] == pic_pkg::EDGE_BOTH) & (rise | fall));
        end
    endgenerate

    // event vector in priority order
    always_comb begin
        events = {i_interval_overflow,
                  i_watchdog_match | i_watch_match,
                  i_conversion_done,
                  i_timer_match,
                  i_sync_serial_done,
                  i_uart1_done,
                  i_uart0_rx_done | i_uart0_tx_done,
                  ext_edge};
    end

    assign iflag = i_processor_status_word[pic_pkg::STATUS_MASTER_BIT];
    // gating: master, enable and request all needed
    assign armed = flags_ff & i_enable_flags & {pic_pkg::NUM_SRC{iflag}};
    assign o_req = pick(armed);

    // flag next values: software write, acceptance clear, then events win
    always_comb begin
        nxt_flags = flags_ff;
        if (i_flag_wr.we) begin
            nxt_flags = i_flag_wr.data;
        end
        if (vec_ff) begin
            // every source is edge or event activated, so all clear here
            nxt_flags[src_ff] = 1'b0;
        end
        nxt_flags = nxt_flags | events;
        nxt_shared = shared_ff & ~i_shared_clr;
        nxt_shared = nxt_shared | {i_uart0_tx_done, i_uart0_rx_done,
                                   i_watch_match, i_watchdog_match};
    end

    // acceptance sequencer: latch winner, count eight cycles
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_src = src_ff;
        nxt_vec = 1'b0;
        nxt_clr = 1'b0;
        case (state_ff)
            pic_pkg::PIC_IDLE: begin
                if (i_accept_start && o_req.valid) begin
                    nxt_state = pic_pkg::PIC_ACCEPT;
                    nxt_src = o_req.src;
                    nxt_cnt = 4'h1;
                    nxt_clr = 1'b1;
                end
            end
            pic_pkg::PIC_ACCEPT: begin
                // last cycle raises the vector strobe
                if (cnt_ff == pic_pkg::ACCEPT_LAST) begin
                    nxt_state = pic_pkg::PIC_DONE;
                    nxt_vec = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end
            pic_pkg::PIC_DONE: begin
                nxt_state = pic_pkg::PIC_IDLE;
                nxt_cnt = 4'h0;
            end
            default: begin
                nxt_state = pic_pkg::PIC_IDLE;
            end
        endcase
    end

    // register all state
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_ff <= 15'h0000;
            shared_ff <= 4'h0;
            state_ff <= pic_pkg::PIC_IDLE;
            cnt_ff <= 4'h0;
            src_ff <= 4'h0;
            vec_ff <= 1'b0;
            clr_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            shared_ff <= nxt_shared;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            src_ff <= nxt_src;
            vec_ff <= nxt_vec;
            clr_ff <= nxt_clr;
        end
    end

    assign o_request_flags = flags_ff;
    assign o_shared_source_flags = shared_ff;
    assign o_busy = (state_ff != pic_pkg::PIC_IDLE);
    assign o_clr_iflag = clr_ff;
    assign o_vector_valid = vec_ff;
    assign o_vector_src = src_ff;

    // vector strobe comes eight cycles after the accept decision
    a_accept_eight: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_ff == pic_pkg::PIC_IDLE && i_accept_start && o_req.valid)
        |-> ##8 o_vector_valid) else $error("vector not after eight cycles");
    // master clear pulses right after an accept
    a_iflag_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_ff == pic_pkg::PIC_IDLE && i_accept_start && o_req.valid)
        |=> o_clr_iflag) else $error("master flag not cleared");
    // no offer while master flag is clear
    a_master_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !iflag |-> !o_req.valid) else $error("offer with master clear");
    // offered source is enabled and requested
    a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_req.valid |-> (i_enable_flags[o_req.src] && flags_ff[o_req.src]))
        else $error("offer of disabled source");
    // no armed source beats the offered one
    a_prio_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_req.valid |-> ((armed & ((15'h0001 << o_req.src) - 15'h0001)) == 15'h0000))
        else $error("lower priority offered");
    // accepted source flag drops unless a new event hits it
    a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_vector_valid && !events[o_vector_src] && !i_flag_wr.we)
        |=> !flags_ff[$past(o_vector_src)]) else $error("flag not cleared");
    // a conversion done event always leaves its flag set
    a_event_sets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_conversion_done |=> flags_ff[pic_pkg::SRC_ADC]) else $error("event lost");
    // pending flag holds without a clear source
    a_flag_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (flags_ff[pic_pkg::SRC_BIT] && !i_flag_wr.we && !vec_ff)
        |=> flags_ff[pic_pkg::SRC_BIT]) else $error("pending flag lost");
endmodule

// >>> pic_core_model.sv
/*
 * behavioural model of the core side of the controller: it owns the
 * master enable bit of the status word and raises acceptance requests.
 * assumes the bench drives i_want and i_ei just after a falling edge.
 */
`timescale 1ns/100ps
module pic_core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // requests from the bench
    input wire logic i_want,
    input wire logic i_ei,
    // controller outputs seen by the core
    input wire logic i_clr_iflag,
    input wire logic i_busy,
    // toward the controller
    output logic [7:0] o_status_word,
    output logic o_accept_start
);
    logic master_ff; // master enable held by the core

    // clear wins over a set in the same cycle, as the core would
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            master_ff <= 1'b0;
        end else if (i_clr_iflag) begin
            master_ff <= 1'b0;
        end else if (i_ei) begin
            master_ff <= 1'b1;
        end
    end

    // only the master bit is modelled, other bits stay low
    assign o_status_word = {5'h0, master_ff, 2'h0};
    // request held at instruction end, withdrawn while a sequence runs
    assign o_accept_start = i_want & ~i_busy;
endmodule

// >>> pic_ctrl_tb.sv
/*
 * self-checking bench for the interrupt controller: event sources, pin
 * edge modes, gating, priority order and the acceptance sequence.
 * assumes the core model file is compiled before this one.
 */
`timescale 1ns/100ps
module pic_ctrl_tb;
    logic i_clk, i_arst_n, want, ei, clr, busy, vvalid, acc;
    logic [3:0] pins, shr_clr, shared, vsrc;
    logic [7:0] sel, stat_word;
    logic [12:0] ev; // all event pulses, timers in the low bits
    logic [14:0] en, flags, exp_f;
    pic_pkg::pic_flag_wr_type fwr;
    pic_pkg::pic_req_type req;
    int err_total, checked, n, i, g, m;
    // flag index hit by each event bit
    int idx_tab [13] = '{7, 8, 9, 10, 11, 14, 12, 13, 13, 4, 4, 5, 6};

    pic_ctrl pic_ctrl_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ext_pin(pins),
        .i_external_edge_select(sel), .i_timer_match(ev[4:0]),
        .i_interval_overflow(ev[5]), .i_conversion_done(ev[6]),
        .i_watchdog_match(ev[7]), .i_watch_match(ev[8]), .i_uart0_rx_done(ev[9]),
        .i_uart0_tx_done(ev[10]), .i_uart1_done(ev[11]), .i_sync_serial_done(ev[12]),
        .i_enable_flags(en), .i_processor_status_word(stat_word), .i_flag_wr(fwr),
        .i_shared_clr(shr_clr), .i_accept_start(acc), .o_request_flags(flags),
        .o_shared_source_flags(shared), .o_req(req), .o_busy(busy),
        .o_clr_iflag(clr), .o_vector_valid(vvalid), .o_vector_src(vsrc));

    pic_core_model pic_core_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_want(want), .i_ei(ei), .i_clr_iflag(clr), .i_busy(busy),
        .o_status_word(stat_word), .o_accept_start(acc));

    // free running clock, 50 ns period
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic chk(input logic [14:0] got, input logic [14:0] exp_v, input string what);
        checked++;
        if (got !== exp_v) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp_v);
        end
    endtask

    task automatic wrap_up;
        if (err_total == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // inputs only move at falling edges
    task automatic step(input int k);
        repeat (k) @(negedge i_clk);
    endtask

    // software write of the whole flag vector, one cycle strobe
    task automatic wflags(input logic [14:0] v);
        fwr = {1'b1, v};
        step(1);
        fwr.we = 1'b0;
    endtask

    // bounded wait for a one-cycle pulse, counts falling edges passed
    task automatic wait_hi(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        if (s !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: handshake timed out", $time);
            wrap_up;
        end
    endtask

    initial begin
        i_arst_n = 1'b0; want = 1'b0; ei = 1'b0; pins = 4'hf; shr_clr = 4'h0;
        // both-edge mode armed over reset: a false edge would show up as a flag
        sel = 8'hff; ev = 13'h0000; en = 15'h0000; fwr = '0;
        err_total = 0; checked = 0;
        step(10);
        chk(flags, 15'h0000, "flags in reset");
        i_arst_n = 1'b1;
        step(1);
        chk(15'(req), 15'h0000, "offer after reset");
        // each peripheral event lands on its mapped flag, master still off
        for (i = 0; i < 13; i++) begin
            wflags(15'h0000);
            ev = 13'(1) << i;
            step(1);
            ev = 13'h0000;
            chk(flags, 15'(1) << idx_tab[i], "event flag");
            chk(15'(req.valid), 15'h0000, "offer with master off");
        end
        chk(15'(shared), 15'h000f, "shared source record");
        shr_clr = 4'hf;
        step(1);
        shr_clr = 4'h0;
        chk(15'(shared), 15'h0000, "shared source clear");
        // every edge mode on every pin, falling then rising
        for (g = 0; g < 4; g++) begin
            for (m = 0; m < 4; m++) begin
                sel = 8'(m) << (2 * g);
                wflags(15'h0000);
                pins[g] = 1'b0;
                step(5);
                chk(flags, 15'(m & 1) << g, "falling edge flag");
                wflags(15'h0000);
                pins[g] = 1'b1;
                step(5);
                chk(flags, 15'((m >> 1) & 1) << g, "rising edge flag");
            end
        end
        // all pending, pin 0 disabled: sources taken in priority order
        en = 15'h7ffe;
        wflags(15'h7fff);
        exp_f = 15'h7fff;
        for (i = 1; i < 15; i++) begin
            ei = 1'b1;
            step(1);
            ei = 1'b0;
            chk(15'(req), 15'(16 + i), "offered source");
            want = 1'b1;
            wait_hi(clr);
            chk(15'(busy), 15'h0001, "busy during acceptance");
            wait_hi(vvalid);
            chk(15'(n), 15'h0007, "acceptance length");
            chk(15'(vsrc), 15'(i), "vectored source");
            want = 1'b0;
            step(2);
            chk(15'(busy), 15'h0000, "busy after acceptance");
            exp_f[i] = 1'b0;
            chk(flags, exp_f, "flags after acceptance");
        end
        ei = 1'b1;
        step(1);
        ei = 1'b0;
        chk(15'(req.valid), 15'h0000, "disabled source offered");
        // mid-run reset drops the pending pin 0 flag, no false edge after it
        i_arst_n = 1'b0;
        step(2);
        chk(flags, 15'h0000, "flags cleared by reset");
        i_arst_n = 1'b1;
        step(4);
        chk(flags, 15'h0000, "false edge after reset");
        chk(15'(vsrc), 15'h0000, "vector source after reset");
        wrap_up;
    end
endmodule
